// *** design/config_readback_write_lock.sv ***
// Readback select, latch-level and write-lock control held in the last configuration register
// Overview of operation
// - Latch-level field states latch pin level during readback
// - Bit 21: zero holds latch low, one high
// - Bits 20:16 select readback register; some codes reserved
// - Register 12 readback echoes select in 20:16
// - Control register readback: lock bit in bit 5, register address in bits 4:0
// - Lock set blocks writes to registers 0-30
// - Readback works whether locked or unlocked
`timescale 1ns/1ps
module config_readback_write_lock
  import readback_lock_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Decoded serial write: one-cycle strobe when a full word has been latched
  input wire logic i_wr_stb,
  input wire logic [4:0] i_wr_addr,
  input wire logic [31:0] i_wr_data,
  // Contents of the lower register currently named by the readback select
  input wire logic [31:0] i_lower_word,
  // Gated write toward the lower configuration registers
  output logic o_cfg_wr_stb,
  output logic [4:0] o_cfg_wr_addr,
  output logic [31:0] o_cfg_wr_data,
  // One-cycle pulse when a write was dropped by the lock
  output logic o_wr_blocked,
  // Readback controls and word
  output logic [4:0] o_readback_sel,
  output logic o_readback_latch_level_sel,
  output logic o_readback_sel_reserved,
  output logic [31:0] o_readback_word,
  output logic o_serial_write_lock
);

  // Kinds of write seen on the port
  typedef enum logic [1:0] {
    NO_WRITE,
    CONTROL_WRITE,
    REFUSED_WRITE,
    FORWARD_WRITE
  } wr_kind_e;

  // All module state in one record
  typedef struct packed {
    // Control register fields
    logic lock;
    logic latch_level;
    logic [4:0] sel;
    // Forwarded write toward the lower registers
    logic wr_stb;
    logic [4:0] wr_addr;
    logic [31:0] wr_data;
    // Pulse for a write dropped by the lock
    logic blocked;
    // Readback word and the reserved flag that goes with it
    logic reserved;
    logic [31:0] rb_word;
  } state_s;

  // Registered state, its next value, word former outputs and write kind
  state_s state_q;
  state_s state_d;
  logic mux_reserved;
  logic [31:0] mux_word;
  wr_kind_e wr_kind;

  // Readback select field of a written control word
  function automatic logic [4:0] select_field(input logic [31:0] word);
    select_field = word[SELECT_MSB:SELECT_LSB];
  endfunction : select_field

  // Latch level advised to the host for readback
  function automatic logic latch_level_field(input logic [31:0] word);
    latch_level_field = word[LATCH_LEVEL_BIT];
  endfunction : latch_level_field

  // Lock bit, the only field honoured in a control-register readback
  function automatic logic lock_field(input logic [31:0] word);
    lock_field = word[LOCK_BIT];
  endfunction : lock_field

  // Address classes; the control register is never lockable
  function automatic logic is_control_addr(input logic [4:0] addr);
    is_control_addr = (addr == READBACK_AND_LOCK_CONTROL_ADDR);
  endfunction : is_control_addr

  // Registers 0 to 30 fall under the lock
  function automatic logic is_lockable_addr(input logic [4:0] addr);
    is_lockable_addr = (addr <= LAST_LOCKED_ADDR);
  endfunction : is_lockable_addr

  // Sort one write; the control register bypasses the lock so it can always unlock
  function automatic wr_kind_e classify_write(input logic stb, input logic [4:0] addr, input logic locked);
    if (!stb) begin
      classify_write = NO_WRITE;
    end else if (is_control_addr(addr)) begin
      classify_write = CONTROL_WRITE;
    end else if (locked && is_lockable_addr(addr)) begin
      classify_write = REFUSED_WRITE;
    end else begin
      classify_write = FORWARD_WRITE;
    end
  endfunction : classify_write

  // Strobes live for one cycle only, so each cycle starts with them low
  function automatic state_s clear_pulses(input state_s cur);
    state_s nxt;
    nxt = cur;
    nxt.wr_stb = 1'b0;
    nxt.blocked = 1'b0;
    clear_pulses = nxt;
  endfunction : clear_pulses

  // Control write: all three fields land together
  function automatic state_s apply_control_write(input state_s cur, input logic [31:0] word);
    state_s nxt;
    nxt = cur;
    nxt.lock = lock_field(word);
    nxt.latch_level = latch_level_field(word);
    nxt.sel = select_field(word);
    apply_control_write = nxt;
  endfunction : apply_control_write

  // Open lower write: address and data held until the next forwarded write
  function automatic state_s apply_forward_write(input state_s cur, input logic [4:0] addr,
    input logic [31:0] data);
    state_s nxt;
    nxt = cur;
    nxt.wr_stb = 1'b1;
    nxt.wr_addr = addr;
    nxt.wr_data = data;
    apply_forward_write = nxt;
  endfunction : apply_forward_write

  // Locked lower write: nothing forwarded, a pulse tells the host side
  function automatic state_s apply_refused_write(input state_s cur);
    state_s nxt;
    nxt = cur;
    nxt.blocked = 1'b1;
    apply_refused_write = nxt;
  endfunction : apply_refused_write

  // Readback word and flag follow the select one cycle later
  function automatic state_s apply_readback(input state_s cur, input logic [31:0] word,
    input logic reserved);
    state_s nxt;
    nxt = cur;
    nxt.rb_word = word;
    nxt.reserved = reserved;
    apply_readback = nxt;
  endfunction : apply_readback

  // Word shaping for the selected register
  readback_word_mux u_mux (
    .i_sel(state_q.sel),
    .i_lock(state_q.lock),
    .i_lower_word(i_lower_word),
    .o_reserved(mux_reserved),
    .o_word(mux_word)
  );

  // Classify the incoming write once per cycle
  assign wr_kind = classify_write(i_wr_stb, i_wr_addr, state_q.lock);

  // Next state; the readback path uses the lock only as bit 5 of the register 31 word, so reads work either way
  always_comb begin
    // Pulses drop first, then the readback stage moves on
    state_d = clear_pulses(state_q);
    state_d = apply_readback(state_d, mux_word, mux_reserved);
    // One write kind at most per cycle
    case (wr_kind)
      CONTROL_WRITE: begin
        state_d = apply_control_write(state_d, i_wr_data);
      end
      REFUSED_WRITE: begin
        state_d = apply_refused_write(state_d);
      end
      FORWARD_WRITE: begin
        state_d = apply_forward_write(state_d, i_wr_addr, i_wr_data);
      end
      default: begin
        // Nothing arrived this cycle
      end
    endcase
  end

  // State register; lock starts cleared so setup writes land at once
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // Control fields
      state_q.lock <= LOCK_RESET;
      state_q.latch_level <= LATCH_LEVEL_RESET;
      state_q.sel <= SELECT_RESET;
      // Forwarded write and refusal pulse
      state_q.wr_stb <= 1'b0;
      state_q.wr_addr <= SELECT_RESET;
      state_q.wr_data <= WORD_ZERO;
      state_q.blocked <= 1'b0;
      // Readback word
      state_q.reserved <= 1'b0;
      state_q.rb_word <= WORD_ZERO;
    end else begin
      state_q <= state_d;
    end
  end

  // Write-port outputs straight from the state record
  assign o_cfg_wr_stb = state_q.wr_stb;
  assign o_cfg_wr_addr = state_q.wr_addr;
  assign o_cfg_wr_data = state_q.wr_data;
  assign o_wr_blocked = state_q.blocked;

  // Readback controls; the latch level is only advice for the host side
  assign o_readback_sel = state_q.sel;
  assign o_readback_latch_level_sel = state_q.latch_level;
  assign o_readback_sel_reserved = state_q.reserved;
  assign o_readback_word = state_q.rb_word;
  assign o_serial_write_lock = state_q.lock;

endmodule : config_readback_write_lock

// *** design/readback_lock_pkg.sv ***
// Package: register layout and field positions for the readback and write-lock register
package readback_lock_pkg;

  // Register numbering on the serial configuration interface
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [4:0] READBACK_AND_LOCK_CONTROL_ADDR = 5'h1F;
  localparam logic [4:0] LAST_LOCKED_ADDR = 5'h1E;
  localparam logic [4:0] ECHO_SELECT_ADDR = 5'h0C;

  // Field positions inside the control register
  localparam int LATCH_LEVEL_BIT = 21;
  localparam int SELECT_MSB = 20;
  localparam int SELECT_LSB = 16;
  localparam int LOCK_BIT = 5;

  // Field positions of the select echo inside a register 12 readback word
  localparam int ECHO_MSB = 20;
  localparam int ECHO_LSB = 16;

  // Reserved readback select codes
  localparam logic [4:0] RESERVED_SEL_A = 5'h09;
  localparam logic [4:0] RESERVED_SEL_LO = 5'h10;
  localparam logic [4:0] RESERVED_SEL_HI = 5'h17;

  // Values after reset
  localparam logic LOCK_RESET = 1'b0;
  localparam logic LATCH_LEVEL_RESET = 1'b0;
  localparam logic [4:0] SELECT_RESET = 5'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage : readback_lock_pkg

// *** design/readback_word_mux.sv ***
// Readback word former: picks and shapes the word returned for the selected register
`timescale 1ns/1ps
module readback_word_mux
  import readback_lock_pkg::*;
(
  input wire logic [4:0] i_sel,
  input wire logic i_lock,
  input wire logic [31:0] i_lower_word,
  output logic o_reserved,
  output logic [31:0] o_word
);

  // Reserved select codes name no register
  function automatic logic is_reserved(input logic [4:0] sel);
    is_reserved = (sel == RESERVED_SEL_A) || ((sel >= RESERVED_SEL_LO) && (sel <= RESERVED_SEL_HI));
  endfunction : is_reserved

  // Shape the word; reserved codes return zero so the host never sees stale data
  always_comb begin
    o_reserved = is_reserved(i_sel);
    o_word = i_lower_word;
    if (o_reserved) begin
      o_word = WORD_ZERO;
    end else if (i_sel == READBACK_AND_LOCK_CONTROL_ADDR) begin
      // Lock bit carries content and bits 4:0 return the register address; upper bits driven zero
      o_word = WORD_ZERO;
      o_word[LOCK_BIT] = i_lock;
      o_word[ADDR_W-1:0] = READBACK_AND_LOCK_CONTROL_ADDR;
    end else if (i_sel == ECHO_SELECT_ADDR) begin
      o_word[ECHO_MSB:ECHO_LSB] = i_sel;
    end
  end

endmodule : readback_word_mux

// *** testbench/lock_chk.sv ***
// Checker for the readback select, latch level and write-lock control
`timescale 1ns/1ps
module lock_chk (
  input wire logic i_clk, i_rst_n, i_wr_stb, o_cfg_wr_stb, o_wr_blocked,
  input wire logic o_readback_latch_level_sel, o_readback_sel_reserved, o_serial_write_lock,
  input wire logic [4:0] i_wr_addr, o_cfg_wr_addr, o_readback_sel,
  input wire logic [31:0] i_wr_data, i_lower_word, o_cfg_wr_data, o_readback_word
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Writes to the control register versus the lower registers
  sequence top_wr; i_wr_stb && i_wr_addr == 5'h1F; endsequence
  sequence low_wr; i_wr_stb && i_wr_addr != 5'h1F; endsequence
  latch_level_a: assert property (top_wr |=> o_readback_latch_level_sel == $past(i_wr_data[21]))
    else $error("latch level");
  sel_update_a: assert property (top_wr |=> o_readback_sel == $past(i_wr_data[20:16])) else $error("select");
  sel_reserved_a: assert property (o_readback_sel_reserved == ($past(o_readback_sel) inside {5'h09, [5'h10:5'h17]}))
    else $error("reserved flag");
  echo_word_a: assert property (o_readback_sel == 5'h0C |=> o_readback_word ==
    {$past(i_lower_word[31:21]), 5'h0C, $past(i_lower_word[15:0])}) else $error("echo word");
  top_word_a: assert property (o_readback_sel == 5'h1F |=>
    o_readback_word == {26'h0, $past(o_serial_write_lock), 5'h1F}) else $error("top word");
  write_block_a: assert property (low_wr and o_serial_write_lock |=> o_wr_blocked && !o_cfg_wr_stb)
    else $error("locked write");
  write_pass_a: assert property (low_wr and !o_serial_write_lock |=> o_cfg_wr_stb && !o_wr_blocked
    && o_cfg_wr_data == $past(i_wr_data) && o_cfg_wr_addr == $past(i_wr_addr)) else $error("open write");
  lock_update_a: assert property (top_wr |=> o_serial_write_lock == $past(i_wr_data[5]) && !o_cfg_wr_stb)
    else $error("lock bit");
endmodule : lock_chk
bind config_readback_write_lock lock_chk lock_chk_inst (.*);

// *** testbench/host_model.sv ***
// Lower configuration registers behind the forwarded write port
`timescale 1ns/1ps
module host_model (
  input wire logic i_clk, i_stb,
  input wire logic [4:0] i_addr, i_sel,
  input wire logic [31:0] i_data,
  output logic [31:0] o_word
);
  logic [31:0] regs_q [32];
  // Unwritten registers hold a pattern, so a stale read never looks like zero
  initial foreach (regs_q[k]) regs_q[k] = ~32'(k);
  always @(posedge i_clk) if (i_stb) regs_q[i_addr] <= i_data;
  assign o_word = regs_q[i_sel];
endmodule : host_model

// *** testbench/testbench.sv ***
// Testbench: writes through the word port, readback and lock checks
`timescale 1ns/1ps
module testbench;
  logic i_clk = 0, i_rst_n = 0, i_wr_stb = 0, stb, blk, lvl, rsv, lck;
  logic [4:0] i_wr_addr = 0, cadr, sel;
  logic [31:0] i_wr_data = 0, i_lower_word, cdat, word;
  int n_mismatch = 0, compares = 0;
  always #12.5 i_clk = ~i_clk;
  config_readback_write_lock config_readback_write_lock_inst (.i_clk, .i_rst_n, .i_wr_stb, .i_wr_addr,
    .i_wr_data, .i_lower_word, .o_cfg_wr_stb(stb), .o_cfg_wr_addr(cadr), .o_cfg_wr_data(cdat),
    .o_wr_blocked(blk), .o_readback_sel(sel), .o_readback_latch_level_sel(lvl),
    .o_readback_sel_reserved(rsv), .o_readback_word(word), .o_serial_write_lock(lck));
  host_model host_model_inst (.i_clk, .i_stb(stb), .i_addr(cadr), .i_sel(sel), .i_data(cdat), .o_word(i_lower_word));
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // One strobed word; strobes land one cycle later
  task automatic wr(logic [4:0] a, logic [31:0] d);
    @(posedge i_clk) #1;
    {i_wr_stb, i_wr_addr, i_wr_data} = {1'b1, a, d};
    @(posedge i_clk) #1;
    i_wr_stb = 0;
  endtask : wr
  task automatic rd(logic [31:0] exp);
    repeat (2) @(posedge i_clk);
    #1 chk(word, exp);
  endtask : rd
  task automatic finish_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // Watchdog well beyond the roughly 140 cycles of the sequence
  initial begin
    #20us n_mismatch++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge i_clk);
    #1 i_rst_n = 1;
    chk({lck, lvl, sel}, 0);
    wr(5'h03, 32'hA5A5_0003);
    chk({stb, cadr}, {1'b1, 5'h03});
    wr(5'h0C, 32'h1234_5678);
    wr(5'h1F, 32'h0023_0000);
    chk(lvl, 1);
    chk(sel, 5'h03);
    rd(32'hA5A5_0003);
    wr(5'h1F, 32'h000C_0000);
    chk(lvl, 0);
    rd(32'h122C_5678);
    for (int k = 0; k < 32; k++) begin
      wr(5'h1F, 32'(k) << 16);
      @(posedge i_clk) #1 chk(rsv, k inside {9, [16:23]});
    end
    wr(5'h1F, 32'h0009_0000);
    rd(32'h0000_0000);
    wr(5'h1F, 32'h0003_0020);
    wr(5'h03, 32'hDEAD_BEEF);
    chk({blk, stb}, 2'b10);
    rd(32'hA5A5_0003);
    wr(5'h1F, 32'h001F_0020);
    rd(32'h0000_003F);
    wr(5'h1F, 32'h0003_0000);
    wr(5'h03, 32'hDEAD_BEEF);
    chk({blk, stb, lck}, 3'b010);
    chk(cadr, 5'h03);
    chk(cdat, 32'hDEAD_BEEF);
    rd(32'hDEAD_BEEF);
    finish_test();
  end
endmodule : testbench
